/* fpu_issue_and_exception_control.sv */
`timescale 1ns/100ps
// Function
// - Runs beside the integer pipeline, five stages, long execute residency allowed.
// - Any register or resource conflict stalls the whole pipeline.
// - Operations never overlap, except add two cycles into a multiply and non-unit ops (loads, stores, moves, branches).
// - Another multiply may begin four cycles after a single-precision one, five after a double.
// - Minimum latencies for add, multiply, divide, root, move-class operations.
// - Fixed latencies for loads, stores, moves, control words, compare, branches.
// - Same-format conversion is illegal and traps as unimplemented; op_cvt_same here issues as a one-cycle op and traps only on exc_unimpl_detect.
// - Dispatch only without unit conflict, otherwise interlock.
// - Divide needs adder and multiplier idle in execute phase one.
// - Multiply needs adder idle and multiplier idle or six cycles old.
// - Root, convert, negate, absolute, compare need both units idle.
// - Add needs adder idle and multiplier idle or two cycles old.
// - Each IEEE exception has an enable choosing trap or flag.
// - A trap leaves unit state untouched, no destination write.
// - Without trap a default value is written and execution continues.
// - Unimplemented exception has no enable or flag and always traps.
// - Disabled exception sets cause and flag; enabled sets cause and traps.
// - Trap reports floating-point exception code, cause bits give reason.
// - Flags stay set until software writes new flag values.
// - Inexact default rounded result; divide by zero signed infinity.
// - Untrapped underflow traps unimplemented unless flush-subnormal bit set.
// - Overflow default depends on rounding mode and sign.
// - Invalid default result is a quiet not-a-number.
// - With inexact traps enabled, add, multiply and both-unit ops over two cycles raise coproc_stall for one cycle.
// - Overflow also raises inexact cause and flag.
module fpu_issue_and_exception_control
  import fpu_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire fpu_ctrl_pkg::op_t issue_op,
  input wire logic issue_double,
  input wire logic reg_conflict,
  input wire logic [4:0] exc_detect,
  input wire logic exc_unimpl_detect,
  input wire logic exc_valid,
  input wire logic result_sign,
  input wire logic [4:0] trap_enable,
  input wire logic flush_subnormal_bit,
  input wire logic [1:0] round_mode,
  input wire logic flag_write,
  input wire logic [4:0] flag_write_data,
  output logic issue_accept,
  output logic pipe_stall,
  output logic coproc_stall,
  output logic [6:0] op_latency,
  output logic [5:0] cause_bits,
  output logic [4:0] flag_bits,
  output logic trap_taken,
  output logic [2:0] trap_code,
  output logic dest_write,
  output fpu_ctrl_pkg::res_t default_result
);
  typedef struct packed {
    logic [5:0] cause;
    logic [4:0] flags;
    logic trap;
    logic [2:0] code;
    logic wr;
    res_t res;
    logic [6:0] lat;
    logic long_run;
  } ctl_state_t;
  ctl_state_t state;
  ctl_state_t next_state;

  logic add_busy;
  logic mul_busy;
  logic [3:0] mul_since;
  logic is_mul;
  logic is_addsub;
  logic is_both_idle_op;
  logic is_unit_op;
  logic can_issue;
  logic start_add;
  logic start_mul;
  logic [6:0] latency;
  logic [5:0] raised;
  logic [4:0] flag_set;
  logic any_trap;

  // Classification of the offered operation
  assign is_mul = (issue_op == op_mul);
  assign is_addsub = (issue_op == op_add) || (issue_op == op_sub);
  assign is_both_idle_op = (issue_op == op_div) || (issue_op == op_sqrt) ||
    (issue_op == op_cvt) || (issue_op == op_neg) || (issue_op == op_abs) ||
    (issue_op == op_cmp);
  assign is_unit_op = is_mul || is_addsub || is_both_idle_op;

  // Latency table
  always_comb
  begin
    case (issue_op)
      op_add, op_sub: latency = lat_add;
      op_mul: latency = issue_double ? lat_mul_d : lat_mul_s;
      op_div: latency = issue_double ? lat_div_d : lat_div_s;
      op_sqrt: latency = issue_double ? lat_sqrt_d : lat_sqrt_s;
      op_abs, op_mov, op_neg: latency = lat_one;
      op_cvt: latency = lat_cvt;
      op_load, op_move_to, op_move_from, op_ctl_read: latency = lat_two;
      op_store, op_branch: latency = lat_one;
      op_ctl_write, op_cmp: latency = lat_three;
      default: latency = lat_one;
    endcase
  end

  // Issue conditions in execute phase one
  always_comb
  begin
    if (reg_conflict)
      can_issue = 1'b0;
    else if (is_mul)
      can_issue = !add_busy && (!mul_busy || mul_since >= mul_after_mul);
    else if (is_addsub)
      can_issue = !add_busy && (!mul_busy || mul_since >= add_after_mul);
    else if (is_both_idle_op)
      can_issue = !add_busy && !mul_busy;
    else
      can_issue = 1'b1;
  end

  assign issue_accept = (issue_op != op_none) && can_issue;
  assign pipe_stall = (issue_op != op_none) && !can_issue;
  assign start_mul = issue_accept && is_mul;
  assign start_add = issue_accept && (is_addsub || is_both_idle_op);

  // Busy tracking for adder and multiplier
  unit_timer adder_timer (
    .clk(clk),
    .rst(rst),
    .start(start_add),
    .length(latency),
    .busy(add_busy)
  );
  unit_timer mult_timer (
    .clk(clk),
    .rst(rst),
    .start(start_mul || (issue_accept && is_both_idle_op)),
    .length(latency),
    .busy(mul_busy)
  );
  mul_spacing spacing (
    .clk(clk),
    .rst(rst),
    .mul_start(start_mul),
    .since(mul_since)
  );

  // Raised exceptions including implied inexact and underflow to unimplemented
  always_comb
  begin
    raised = '0;
    if (exc_valid)
    begin
      raised[4:0] = exc_detect;
      if (exc_detect[exc_overflow])
        raised[exc_inexact] = 1'b1;
      if (exc_detect[exc_underflow] && !trap_enable[exc_underflow] && !flush_subnormal_bit)
        raised[exc_unimpl] = 1'b1;
      if (exc_detect[exc_underflow] && !trap_enable[exc_underflow] && flush_subnormal_bit)
        raised[exc_inexact] = 1'b1;
      if (exc_unimpl_detect)
        raised[exc_unimpl] = 1'b1;
    end
  end

  assign any_trap = raised[exc_unimpl] || |(raised[4:0] & trap_enable);
  assign flag_set = raised[4:0] & ~trap_enable;

  // Cause, flags, trap and default result
  always_comb
  begin
    next_state = state;
    next_state.lat = issue_accept ? latency : state.lat;
    next_state.long_run = trap_enable[exc_inexact] && issue_accept && is_unit_op &&
      (latency > lat_two);
    if (flag_write)
      next_state.flags = flag_write_data;
    next_state.flags = next_state.flags | flag_set;
    next_state.trap = 1'b0;
    next_state.wr = 1'b0;
    next_state.res = res_none;
    if (exc_valid)
    begin
      next_state.cause = raised;
      if (any_trap)
      begin
        next_state.trap = 1'b1;
        next_state.code = fp_exception_code;
      end
      else
      begin
        next_state.wr = 1'b1;
        if (raised[exc_invalid])
          next_state.res = res_quiet_nan;
        else if (raised[exc_divzero])
          next_state.res = res_signed_inf;
        else if (raised[exc_overflow])
        begin
          case (round_mode)
            round_nearest: next_state.res = res_signed_inf;
            round_toward_zero: next_state.res = res_largest_finite;
            round_toward_plus:
              next_state.res = result_sign ? res_largest_finite : res_signed_inf;
            round_toward_minus:
              next_state.res = result_sign ? res_signed_inf : res_largest_finite;
            default: next_state.res = res_signed_inf;
          endcase
        end
        else
          next_state.res = res_rounded;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= '{cause: '0, flags: '0, trap: 1'b0, code: '0, wr: 1'b0, res: res_none,
        lat: '0, long_run: 1'b0};
    else
      state <= next_state;
  end

  assign cause_bits = state.cause;
  assign flag_bits = state.flags;
  assign trap_taken = state.trap;
  assign trap_code = state.code;
  assign dest_write = state.wr;
  assign default_result = state.res;
  assign op_latency = state.lat;
  assign coproc_stall = state.long_run;

  property p_mul_spacing;
    @(posedge clk) disable iff (rst)
    start_mul |-> ##1 (!issue_accept || !is_mul) [*3];
  endproperty
  a_mul_spacing: assert property (p_mul_spacing) else $error("multiply spacing");

  property p_add_after_mul;
    @(posedge clk) disable iff (rst)
    start_mul ##1 (is_addsub && !reg_conflict) |-> !issue_accept;
  endproperty
  a_add_after_mul: assert property (p_add_after_mul) else $error("add too early");

  property p_div_idle;
    @(posedge clk) disable iff (rst)
    (issue_accept && is_both_idle_op) |-> (!add_busy && !mul_busy);
  endproperty
  a_div_idle: assert property (p_div_idle) else $error("unit busy at start");

  property p_conflict_stall;
    @(posedge clk) disable iff (rst)
    (reg_conflict && issue_op != op_none) |-> (pipe_stall && !issue_accept);
  endproperty
  a_conflict_stall: assert property (p_conflict_stall) else $error("no stall");

  property p_trap_no_write;
    @(posedge clk) disable iff (rst)
    trap_taken |-> !dest_write && trap_code == fp_exception_code;
  endproperty
  a_trap_no_write: assert property (p_trap_no_write) else $error("trap wrote");

  property p_unimpl_trap;
    @(posedge clk) disable iff (rst)
    (exc_valid && exc_unimpl_detect) |=> trap_taken && cause_bits[exc_unimpl];
  endproperty
  a_unimpl_trap: assert property (p_unimpl_trap) else $error("unimpl not trapped");

  property p_flag_sticky;
    @(posedge clk) disable iff (rst)
    !flag_write |=> (flag_bits & $past(flag_bits)) == $past(flag_bits);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_ovf_inexact;
    @(posedge clk) disable iff (rst)
    (exc_valid && exc_detect[exc_overflow]) |=> cause_bits[exc_inexact];
  endproperty
  a_ovf_inexact: assert property (p_ovf_inexact) else $error("overflow without inexact");

  property p_nan_default;
    @(posedge clk) disable iff (rst)
    (exc_valid && exc_detect[exc_invalid] && !trap_enable[exc_invalid] &&
      !exc_unimpl_detect && !(|(exc_detect & trap_enable)) &&
      (flush_subnormal_bit || !exc_detect[exc_underflow])) |=>
      dest_write && default_result == res_quiet_nan;
  endproperty
  a_nan_default: assert property (p_nan_default) else $error("no quiet nan");

  property p_mul_four;
    @(posedge clk) disable iff (rst)
    (start_mul && !issue_double) ##4 (is_mul && !reg_conflict && !add_busy) |-> issue_accept;
  endproperty
  a_mul_four: assert property (p_mul_four) else $error("multiply held too long");

  property p_add_two;
    @(posedge clk) disable iff (rst)
    start_mul ##2 (is_addsub && !reg_conflict && !add_busy) |-> issue_accept;
  endproperty
  a_add_two: assert property (p_add_two) else $error("add held too long");

  property p_idle_issue;
    @(posedge clk) disable iff (rst)
    (issue_op != op_none && !reg_conflict && !add_busy && !mul_busy) |-> issue_accept;
  endproperty
  a_idle_issue: assert property (p_idle_issue) else $error("needless interlock");

  property p_div_lat;
    @(posedge clk) disable iff (rst)
    (issue_accept && issue_op == op_div && issue_double) |=> op_latency == lat_div_d;
  endproperty
  a_div_lat: assert property (p_div_lat) else $error("divide latency");

  property p_long_run;
    @(posedge clk) disable iff (rst)
    (issue_accept && trap_enable[exc_inexact] && (is_mul || is_addsub)) |=> coproc_stall;
  endproperty
  a_long_run: assert property (p_long_run) else $error("no coprocessor stall");

  property p_flag_load;
    @(posedge clk) disable iff (rst)
    (flag_write && !exc_valid) |=> flag_bits == $past(flag_write_data);
  endproperty
  a_flag_load: assert property (p_flag_load) else $error("flag write lost");

  property p_set_wins;
    @(posedge clk) disable iff (rst)
    (flag_write && exc_valid && exc_detect[exc_divzero] && !trap_enable[exc_divzero]) |=>
      flag_bits[exc_divzero];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag set lost to write");

  property p_underflow_unimpl;
    @(posedge clk) disable iff (rst)
    (exc_valid && exc_detect[exc_underflow] && !trap_enable[exc_underflow] &&
      !flush_subnormal_bit) |=> trap_taken && cause_bits[exc_unimpl];
  endproperty
  a_underflow_unimpl: assert property (p_underflow_unimpl) else $error("underflow");

  property p_enabled_trap;
    @(posedge clk) disable iff (rst)
    (exc_valid && |(exc_detect & trap_enable)) |=> trap_taken;
  endproperty
  a_enabled_trap: assert property (p_enabled_trap) else $error("enabled not trapped");
endmodule

/* fpu_ctrl_pkg.sv */
package fpu_ctrl_pkg;
  // Operation classes
  typedef enum logic [4:0] {
    op_none, op_add, op_sub, op_mul, op_div, op_sqrt, op_abs, op_mov, op_neg,
    op_cvt_same, op_cvt, op_cmp, op_load, op_store, op_move_to, op_move_from,
    op_ctl_write, op_ctl_read, op_branch
  } op_t;
  // Rounding modes
  localparam logic [1:0] round_nearest = 2'h0;
  localparam logic [1:0] round_toward_zero = 2'h1;
  localparam logic [1:0] round_toward_plus = 2'h2;
  localparam logic [1:0] round_toward_minus = 2'h3;
  // Exception bit positions
  localparam int exc_inexact = 0;
  localparam int exc_underflow = 1;
  localparam int exc_overflow = 2;
  localparam int exc_divzero = 3;
  localparam int exc_invalid = 4;
  localparam int exc_unimpl = 5;
  // Latencies in cycles
  localparam logic [6:0] lat_add = 7'h04;
  localparam logic [6:0] lat_mul_s = 7'h04;
  localparam logic [6:0] lat_mul_d = 7'h05;
  localparam logic [6:0] lat_div_s = 7'h20;
  localparam logic [6:0] lat_div_d = 7'h3d;
  localparam logic [6:0] lat_sqrt_s = 7'h1f;
  localparam logic [6:0] lat_sqrt_d = 7'h3c;
  localparam logic [6:0] lat_one = 7'h01;
  localparam logic [6:0] lat_two = 7'h02;
  localparam logic [6:0] lat_three = 7'h03;
  localparam logic [6:0] lat_cvt = 7'h04;
  // Multiply spacing and trap code
  localparam logic [3:0] mul_after_mul = 4'h6;
  localparam logic [3:0] add_after_mul = 4'h2;
  localparam logic [3:0] since_max = 4'hf;
  localparam logic [2:0] fp_exception_code = 3'h7;
  // Default result codes
  typedef enum logic [2:0] {
    res_rounded, res_signed_inf, res_largest_finite, res_quiet_nan, res_none
  } res_t;
endpackage

/* unit_timer.sv */
`timescale 1ns/100ps
// Busy countdown for one execution unit
module unit_timer
  import fpu_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [6:0] length,
  output logic busy
);
  typedef struct packed {
    logic [6:0] left;
  } timer_state_t;
  timer_state_t state;
  timer_state_t next_state;

  // Load on start, count down otherwise
  always_comb
  begin
    next_state = state;
    if (start)
      next_state.left = length - lat_one;
    else if (state.left != 7'h00)
      next_state.left = state.left - lat_one;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign busy = (state.left != 7'h00);
endmodule

/* mul_spacing.sv */
`timescale 1ns/100ps
// Cycles since the last multiply start, saturating
module mul_spacing
  import fpu_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mul_start,
  output logic [3:0] since
);
  typedef struct packed {
    logic [3:0] count;
  } spacing_state_t;
  spacing_state_t state;
  spacing_state_t next_state;

  // Restart at one so the start cycle itself counts as cycle zero
  always_comb
  begin
    next_state = state;
    if (mul_start)
      next_state.count = 4'h1;
    else if (state.count != since_max)
      next_state.count = state.count + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= '{count: since_max};
    else
      state <= next_state;
  end

  assign since = state.count;
endmodule

/* int_pipe_model.sv */
`timescale 1ns/100ps
// Integer pipeline side: offers one op and holds it while stalled
module int_pipe_model
  import fpu_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic issue_accept,
  input wire logic offer,
  input wire fpu_ctrl_pkg::op_t offer_op,
  input wire logic offer_double,
  output fpu_ctrl_pkg::op_t issue_op,
  output logic issue_double,
  output logic took
);
  // Load a new op only once the held one was accepted
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      issue_op <= op_none;
      issue_double <= 1'b0;
      took <= 1'b0;
    end
    else
    begin
      took <= 1'b0;
      if (issue_op == op_none || issue_accept)
      begin
        issue_op <= offer ? offer_op : op_none;
        issue_double <= offer ? offer_double : ~issue_double;
        took <= offer;
      end
    end
  end
endmodule

/* test_fpu_issue_and_exception_control.sv */
`timescale 1ns/100ps
module test_fpu_issue_and_exception_control;
  import fpu_ctrl_pkg::*;
  typedef struct {logic [7:0] st; logic [6:0] lat; logic cs;} iss_t;
  typedef struct {logic [5:0] cause; logic [4:0] flags; logic trap; res_t res;} exn_t;
  logic clk = 0, rst = 1, issue_double, took, offer = 0, offer_double = 0;
  op_t issue_op, offer_op = op_none;
  logic reg_conflict = 0, exc_unimpl_detect = 0, exc_valid = 0, result_sign = 0;
  logic [4:0] exc_detect = 0, trap_enable = 0, flag_write_data = 0, shadow = 0;
  logic flush_subnormal_bit = 0, flag_write = 0, ipend = 0, xpend = 0;
  logic [1:0] round_mode = 0;
  logic issue_accept, pipe_stall, coproc_stall, trap_taken, dest_write;
  logic [6:0] op_latency;
  logic [5:0] cause_bits;
  logic [4:0] flag_bits, d;
  logic [2:0] trap_code;
  res_t default_result;
  logic [7:0] stalls = 0;
  int num_errors = 0, compares = 0, cycles = 0, k;
  iss_t iq[$], ic;
  exn_t xq[$], xc;

  fpu_issue_and_exception_control DUT (.clk(clk), .rst(rst), .issue_op(issue_op),
    .issue_double(issue_double), .reg_conflict(reg_conflict), .exc_detect(exc_detect),
    .exc_unimpl_detect(exc_unimpl_detect), .exc_valid(exc_valid),
    .result_sign(result_sign), .trap_enable(trap_enable),
    .flush_subnormal_bit(flush_subnormal_bit), .round_mode(round_mode),
    .flag_write(flag_write), .flag_write_data(flag_write_data),
    .issue_accept(issue_accept), .pipe_stall(pipe_stall), .coproc_stall(coproc_stall),
    .op_latency(op_latency), .cause_bits(cause_bits), .flag_bits(flag_bits),
    .trap_taken(trap_taken), .trap_code(trap_code), .dest_write(dest_write),
    .default_result(default_result));
  int_pipe_model pipe (.clk(clk), .rst(rst), .issue_accept(issue_accept), .offer(offer),
    .offer_op(offer_op), .offer_double(offer_double), .issue_op(issue_op),
    .issue_double(issue_double), .took(took));

  always #5 clk = ~clk;

  // Compare one value and count it
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  // Watcher: settled outputs checked against the oldest notes
  always @(negedge clk)
  begin
    if (ipend)
    begin
      check("op_latency", op_latency, ic.lat);
      check("coproc_stall", coproc_stall, ic.cs);
    end
    ipend = 0;
    if (xpend)
    begin
      xc = xq.pop_front();
      check("cause_bits", cause_bits, xc.cause);
      check("flag_bits", flag_bits, xc.flags);
      check("trap_taken", trap_taken, xc.trap);
      check("dest_write", dest_write, !xc.trap);
      check("default_result", default_result, xc.res);
      if (xc.trap)
        check("trap_code", trap_code, fp_exception_code);
    end
    xpend = exc_valid;
    if (pipe_stall)
      stalls++;
    if (issue_accept)
    begin
      ic = iq.pop_front();
      check("stall_cycles", stalls, ic.st);
      stalls = 0;
      ipend = 1;
    end
  end

  // Offer one op and wait until the pipeline side holds it
  task automatic put(op_t op, logic dbl, logic [7:0] st, logic [6:0] lat);
    iq.push_back('{st, lat, lat > 7'h02 && trap_enable[0]});
    offer = 1;
    offer_op = op;
    offer_double = dbl;
    // Let one edge pass so a stale took from the last op is not seen
    @(posedge clk);
    #1;
    for (int i = 0; i < 200 && !took; i++)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  // Two ops back to back, then let every unit drain
  task automatic pair(op_t a, logic ad, logic [6:0] la, op_t b, logic bd, logic [6:0] lb,
    logic [7:0] st);
    put(a, ad, 8'h00, la);
    put(b, bd, st, lb);
    offer = 0;
    repeat (70) @(posedge clk);
    #1;
  endtask

  // One exception event, expectation built from the trap and default rules
  task automatic exc(logic [4:0] dd, logic u, logic [4:0] e);
    exn_t x;
    logic [4:0] ef;
    logic uu;
    uu = u | (dd[exc_underflow] & !e[exc_underflow] & !flush_subnormal_bit);
    ef = dd | {4'h0, dd[exc_overflow] |
      (dd[exc_underflow] & !e[exc_underflow] & flush_subnormal_bit)};
    x.trap = uu | (|(ef & e));
    x.cause = {uu, ef};
    shadow = shadow | (ef & ~e);
    x.flags = shadow;
    x.res = x.trap ? res_none : ef[4] ? res_quiet_nan : ef[3] ? res_signed_inf :
      !ef[2] ? res_rounded : (round_mode == round_nearest ||
      (round_mode == round_toward_plus && !result_sign) ||
      (round_mode == round_toward_minus && result_sign)) ? res_signed_inf :
      res_largest_finite;
    xq.push_back(x);
    exc_detect = dd;
    exc_unimpl_detect = u;
    trap_enable = e;
    exc_valid = 1;
    @(posedge clk);
    #1;
  endtask

  initial
  begin
    void'($urandom(65));
    repeat (2) @(posedge clk);
    #1 rst = 0;
    pair(op_mul, 0, lat_mul_s, op_add, 0, lat_add, 8'h01);
    pair(op_mul, 0, lat_mul_s, op_mul, 0, lat_mul_s, 8'h03);
    pair(op_mul, 1, lat_mul_d, op_mul, 1, lat_mul_d, 8'h04);
    pair(op_add, 0, lat_add, op_add, 1, lat_add, 8'h03);
    pair(op_add, 0, lat_add, op_mul, 0, lat_mul_s, 8'h03);
    pair(op_mul, 1, lat_mul_d, op_div, 0, lat_div_s, 8'h04);
    pair(op_div, 1, lat_div_d, op_sub, 0, lat_add, 8'h3c);
    pair(op_cmp, 0, lat_three, op_cvt, 0, lat_cvt, 8'h02);
    pair(op_sqrt, 0, lat_sqrt_s, op_neg, 0, lat_one, 8'h1e);
    pair(op_neg, 0, lat_one, op_add, 0, lat_add, 8'h00);
    pair(op_store, 0, lat_one, op_ctl_write, 0, lat_three, 8'h00);
    pair(op_move_to, 0, lat_two, op_move_from, 0, lat_two, 8'h00);
    pair(op_ctl_read, 0, lat_two, op_branch, 0, lat_one, 8'h00);
    pair(op_mov, 0, lat_one, op_div, 0, lat_div_s, 8'h00);
    trap_enable = 5'h01;
    pair(op_sqrt, 1, lat_sqrt_d, op_load, 0, lat_two, 8'h00);
    pair(op_mul, 0, lat_mul_s, op_abs, 0, lat_one, 8'h03);
    trap_enable = 5'h00;
    reg_conflict = 1;
    put(op_add, 0, 8'h03, lat_add);
    offer = 0;
    repeat (3) @(posedge clk);
    #1 reg_conflict = 0;
    repeat (10) @(posedge clk);
    #1 $display("issue tests done");
    for (int i = 0; i < 8; i++)
    begin
      round_mode = i[1:0];
      result_sign = i[2];
      exc(5'h04, 0, 5'h00);
    end
    for (int i = 0; i < 40; i++)
    begin
      round_mode = $urandom;
      result_sign = $urandom;
      d = $urandom & 5'h1d;
      if (d == 5'h00)
        d = 5'h08;
      k = $urandom % 3;
      exc(k == 0 ? 5'h00 : d, k == 0, k == 1 ? 5'h1f : 5'h00);
    end
    exc(5'h02, 0, 5'h00);
    exc(5'h02, 0, 5'h02);
    flush_subnormal_bit = 1;
    exc(5'h02, 0, 5'h00);
    flush_subnormal_bit = 0;
    flag_write = 1;
    flag_write_data = 5'h04;
    shadow = 5'h04;
    exc(5'h08, 0, 5'h00);
    exc_valid = 0;
    flag_write = 1;
    flag_write_data = 5'h0a;
    shadow = 5'h0a;
    @(posedge clk);
    #1 flag_write = 0;
    @(negedge clk);
    check("flag_bits", flag_bits, {3'h0, shadow});
    @(posedge clk);
    #1;
    exc(5'h01, 0, 5'h00);
    exc_valid = 0;
    repeat (5) @(posedge clk);
    $display("exception tests done");
    conclude();
  end
endmodule
